// ### rtcw_pkg.sv
package rtcw_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [11:0] RTCW_OFF_CTRL   = 12'h000;
  localparam logic [11:0] RTCW_OFF_WINDOW = 12'h004;

  // control register fields
  localparam int RTCW_CTRL_PTR_LO = 0;
  localparam int RTCW_CTRL_UNLOCK = 8;

  // ------------------------------------------------------------------
  // view field positions
  // ------------------------------------------------------------------
  localparam int RTCW_WEEKDAY_DIGIT_LO = 8;
  localparam int RTCW_HRT_LO  = 4;
  localparam int RTCW_HRO_LO  = 0;
  localparam int RTCW_MINT_LO = 12;
  localparam int RTCW_MINO_LO = 8;
  localparam int RTCW_SECT_LO = 4;
  localparam int RTCW_SECO_LO = 0;

  // bits that hold state in each view; the rest read zero
  localparam logic [15:0] RTCW_WH_MASK = 16'h073f;
  localparam logic [15:0] RTCW_MS_MASK = 16'h7f7f;

  // pointer codes
  localparam logic [1:0] RTCW_PTR_MS = 2'h0;
  localparam logic [1:0] RTCW_PTR_WH = 2'h1;

  // field maxima
  localparam logic [2:0] RTCW_WEEKDAY_DIGIT_MAX = 3'h6;
  localparam logic [1:0] RTCW_HRT_MAX  = 2'h2;
  localparam logic [3:0] RTCW_ONE_MAX  = 4'h9;
  localparam logic [2:0] RTCW_TEN_MAX  = 3'h5;
  localparam logic [3:0] RTCW_HR23_ONE = 4'h3;

  // control reset values
  localparam logic [1:0] RTCW_PTR_RST    = 2'h0;
  localparam logic       RTCW_UNLOCK_RST = 1'b0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int RTCW_CLK_HZ    = 20_000_000;
  localparam int RTCW_TICK_SEC  = 1;
  localparam int RTCW_TICK_CYC  = RTCW_CLK_HZ * RTCW_TICK_SEC;

endpackage : rtcw_pkg

// ### rtcw_tick.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// one-second enable divider
// ----------------------------------------------------------------------
module rtcw_tick #(
  parameter int DIV = 20_000_000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  import rtcw_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  wire         wrap = (cnt_q == 32'(DIV - 1));

  // count clocks, pulse once per full period
  assign cnt_d = wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= wrap;
    end
  end

endmodule : rtcw_tick

// ### rtcw_window.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module rtcw_window #(
  parameter int TICK_CYC = rtcw_pkg::RTCW_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import rtcw_pkg::*;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [1:0]  ptr_q;
  logic        unlock_q;
  logic [2:0]  weekday_digit_q;
  logic [1:0]  hrt_q;
  logic [3:0]  hro_q;
  logic [2:0]  mint_q;
  logic [3:0]  mino_q;
  logic [2:0]  sect_q;
  logic [3:0]  seco_q;
  logic        tick;

  // answer is registered: one wait state, pready in second access cycle
  wire         acc      = psel & penable & ~pready;
  wire         hit_ctrl = (paddr == RTCW_OFF_CTRL);
  wire         hit_win  = (paddr == RTCW_OFF_WINDOW);
  wire         unmapped = ~(hit_ctrl | hit_win);
  wire         wr       = acc & pwrite;
  wire         wr_ctrl  = wr & hit_ctrl;
  wire         wr_win   = wr & hit_win;
  wire         view_wh  = (ptr_q == RTCW_PTR_WH);
  wire         view_ms  = (ptr_q == RTCW_PTR_MS);
  // locked weekday/hours writes are dropped silently, no error
  wire         wr_wh    = wr_win & view_wh & unlock_q;
  wire         wr_ms    = wr_win & view_ms;
  wire [15:0]  wdat     = pwdata[15:0];

  // byte lanes per view field
  wire         lane0    = pstrb[0];
  wire         lane1    = pstrb[1];

  // ------------------------------------------------------------------
  // read views
  // ------------------------------------------------------------------
  wire [15:0]  wh_view;
  wire [15:0]  ms_view;
  wire [15:0]  win_view;
  wire [31:0]  ctrl_view;
  wire [31:0]  rd_mux;

  // unused positions are simply not wired: they read zero
  assign wh_view = ({5'h00, weekday_digit_q, 2'h0, hrt_q, hro_q})
                   & RTCW_WH_MASK;
  assign ms_view = ({1'b0, mint_q, mino_q, 1'b0, sect_q, seco_q})
                   & RTCW_MS_MASK;
  // pointer values 10 and 11 are views this block does not hold
  assign win_view  = view_wh ? wh_view : (view_ms ? ms_view : 16'h0000);
  assign ctrl_view = {23'h00_0000, unlock_q, 6'h00, ptr_q};
  assign rd_mux    = hit_ctrl ? ctrl_view
                   : (hit_win ? {16'h0000, win_view} : 32'h0000_0000);

  // ------------------------------------------------------------------
  // bcd increment helpers
  // ------------------------------------------------------------------
  function automatic logic [3:0] rtcw_inc4(input logic [3:0] v);
    rtcw_inc4 = v + 4'h1;
  endfunction : rtcw_inc4

  function automatic logic [2:0] rtcw_inc3(input logic [2:0] v,
                                           input logic [2:0] max);
    rtcw_inc3 = (v >= max) ? 3'h0 : v + 3'h1;
  endfunction : rtcw_inc3

  // ------------------------------------------------------------------
  // time-of-day carry chain
  // ------------------------------------------------------------------
  wire         c_so  = tick & (seco_q >= RTCW_ONE_MAX);
  wire         c_st  = c_so & (sect_q >= RTCW_TEN_MAX);
  wire         c_mo  = c_st & (mino_q >= RTCW_ONE_MAX);
  wire         c_mt  = c_mo & (mint_q >= RTCW_TEN_MAX);
  // the day rolls at 23, not at 29
  wire         end_d = (hrt_q >= RTCW_HRT_MAX) & (hro_q >= RTCW_HR23_ONE);
  wire         c_ho  = c_mt & ~end_d & (hro_q >= RTCW_ONE_MAX);
  wire         c_day = c_mt & end_d;

  logic [3:0]  seco_d;
  logic [2:0]  sect_d;
  logic [3:0]  mino_d;
  logic [2:0]  mint_d;
  logic [3:0]  hro_d;
  logic [1:0]  hrt_d;
  logic [2:0]  weekday_digit_d;

  // software write beats the tick in the same cycle for the fields of the lanes it writes
  always_comb begin
    seco_d = seco_q;
    sect_d = sect_q;
    mino_d = mino_q;
    mint_d = mint_q;
    hro_d  = hro_q;
    hrt_d  = hrt_q;
    weekday_digit_d = weekday_digit_q;
    if (tick) begin
      seco_d = c_so ? 4'h0 : rtcw_inc4(seco_q);
    end
    if (c_so) begin
      sect_d = rtcw_inc3(sect_q, RTCW_TEN_MAX);
    end
    if (c_st) begin
      mino_d = c_mo ? 4'h0 : rtcw_inc4(mino_q);
    end
    if (c_mo) begin
      mint_d = rtcw_inc3(mint_q, RTCW_TEN_MAX);
    end
    if (c_mt) begin
      hro_d = (c_ho | c_day) ? 4'h0 : rtcw_inc4(hro_q);
    end
    if (c_ho) begin
      hrt_d = hrt_q + 2'h1;
    end
    if (c_day) begin
      hrt_d  = 2'h0;
      weekday_digit_d = rtcw_inc3(weekday_digit_q, RTCW_WEEKDAY_DIGIT_MAX);
    end
    if (wr_ms & lane0) begin
      seco_d = wdat[RTCW_SECO_LO +: 4];
      sect_d = wdat[RTCW_SECT_LO +: 3];
    end
    if (wr_ms & lane1) begin
      mino_d = wdat[RTCW_MINO_LO +: 4];
      mint_d = wdat[RTCW_MINT_LO +: 3];
    end
    if (wr_wh & lane0) begin
      hro_d = wdat[RTCW_HRO_LO +: 4];
      hrt_d = wdat[RTCW_HRT_LO +: 2];
    end
    if (wr_wh & lane1) begin
      weekday_digit_d = wdat[RTCW_WEEKDAY_DIGIT_LO +: 3];
    end
  end

  // ------------------------------------------------------------------
  // one-second enable
  // ------------------------------------------------------------------
  rtcw_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // time has no architected reset value; zero is used so sim is clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seco_q <= 4'h0;
      sect_q <= 3'h0;
      mino_q <= 4'h0;
      mint_q <= 3'h0;
      hro_q  <= 4'h0;
      hrt_q  <= 2'h0;
      weekday_digit_q <= 3'h0;
    end else begin
      seco_q <= seco_d;
      sect_q <= sect_d;
      mino_q <= mino_d;
      mint_q <= mint_d;
      hro_q  <= hro_d;
      hrt_q  <= hrt_d;
      weekday_digit_q <= weekday_digit_d;
    end
  end

  // control: pointer and unlock bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q    <= RTCW_PTR_RST;
      unlock_q <= RTCW_UNLOCK_RST;
    end else if (wr_ctrl & lane0) begin
      ptr_q    <= pwdata[RTCW_CTRL_PTR_LO +: 2];
    end else if (wr_ctrl & lane1) begin
      unlock_q <= pwdata[RTCW_CTRL_UNLOCK];
    end
  end

  // registered answer, one cycle pulse of pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & unmapped;
      prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : rtcw_window

// ### rtcw_window_asserts.sv
`timescale 1ns/10ps
module rtcw_window_asserts
  import rtcw_pkg::*;
#(
  parameter int TICK_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [1:0] ptr_q;
  // pointer shadow, so the view checks know which pair is shown
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ptr_q <= RTCW_PTR_RST;
    else if (pready && pwrite && paddr == RTCW_OFF_CTRL && pstrb[0])
      ptr_q <= pwdata[1:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence taken_s; psel && penable && !pready; endsequence
  sequence win_rd_s; pready && !pwrite && paddr == RTCW_OFF_WINDOW;
  endsequence
  one_wait_a:
    assert property (taken_s |=> pready ##1 !pready)
    else $error("access not answered after one wait state");
  no_request_a:
    assert property (!(psel && penable) |=> !pready)
    else $error("answer without a request");
  err_decode_a:
    assert property (pready |-> pslverr ==
      !(paddr == RTCW_OFF_CTRL || paddr == RTCW_OFF_WINDOW))
    else $error("error response does not match address");
  idle_zero_a:
    assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside answer cycle");
  unused_zero_a:
    assert property (win_rd_s |-> prdata[31:16] == 16'h0000
      && !prdata[15] && !prdata[7])
    else $error("unused window bits not zero");
  hours_view_a:
    assert property (win_rd_s ##0 ptr_q == RTCW_PTR_WH |->
      (prdata[15:0] & ~RTCW_WH_MASK) == 16'h0000
      && prdata[10:8] <= RTCW_WEEKDAY_DIGIT_MAX && prdata[5:4] <= RTCW_HRT_MAX)
    else $error("weekday and hours view out of range");
  minsec_view_a:
    assert property (win_rd_s ##0 ptr_q == RTCW_PTR_MS |->
      prdata[14:12] <= RTCW_TEN_MAX && prdata[11:8] <= RTCW_ONE_MAX
      && prdata[6:4] <= RTCW_TEN_MAX && prdata[3:0] <= RTCW_ONE_MAX)
    else $error("minutes and seconds view out of range");
  bad_pointer_a:
    assert property (win_rd_s ##0 ptr_q[1] |-> prdata == 32'h0000_0000)
    else $error("window not zero for unused pointer code");
endmodule : rtcw_window_asserts
bind rtcw_window rtcw_window_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### rtcw_window_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module rtcw_window_test;
  import rtcw_pkg::*;
  localparam int TICK = 100;
  localparam logic [15:0] CARRY [4][4] = '{
    '{16'h0109, 16'h0009, 16'h0109, 16'h0010},
    '{16'h0109, 16'h0059, 16'h0109, 16'h0100},
    '{16'h0109, 16'h5959, 16'h0110, 16'h0000},
    '{16'h0623, 16'h5959, 16'h0000, 16'h0000}};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  int          error_cnt = 0, checked = 0, cyc = 0;
  logic [32:0] exp_q[$];
  logic [32:0] want;
  rtcw_window #(.TICK_CYC(TICK)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial forever #25 pclk = ~pclk;
  // cycles since reset release; tests start mid-second, far from a tick
  always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;
  // each answer is matched against the oldest note
  // the note is popped once, so a mismatch report cannot eat the next one
  always @(posedge pclk) if (pready === 1'b1) begin
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("ERROR %0t: answer with no note", $time);
    end else begin
      want = exp_q.pop_front();
      `CHK({pslverr, prdata}, want)
    end
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer
  task automatic ptr(input logic [1:0] p);
    xfer(1'b1, RTCW_OFF_CTRL, 32'(p), 4'h1, 33'h0);
  endtask : ptr
  task automatic wrw(input logic [31:0] d);
    xfer(1'b1, RTCW_OFF_WINDOW, d, 4'h3, 33'h0);
  endtask : wrw
  task automatic rdw(input logic [31:0] e);
    xfer(1'b0, RTCW_OFF_WINDOW, 32'h0000_0000, 4'h0, {1'b0, e});
  endtask : rdw
  task automatic sync();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cyc % TICK != TICK / 2 && n < 2 * TICK);
    if (cyc % TICK != TICK / 2) begin
      error_cnt++;
      conclude();
    end
  endtask : sync
  initial begin
    logic [31:0] v, m;
    int i;
    void'($urandom(32'hb558));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // locked view drops the write; bad pointer and address answer zero
    sync();
    ptr(RTCW_PTR_WH);
    wrw(32'h0000_0312);
    rdw(32'h0000_0000);
    ptr(2'h2);
    rdw(32'h0000_0000);
    xfer(1'b0, 12'h008, 32'h0000_0000, 4'h0, {1'b1, 32'h0000_0000});
    $display("test locked done");
    xfer(1'b1, RTCW_OFF_CTRL, 32'h0000_0100, 4'h2, 33'h0);
    // unlock lands on its own lane, pointer 10 is kept
    xfer(1'b0, RTCW_OFF_CTRL, 32'h0000_0000, 4'h0, 33'h0_0000_0102);
    // random in-range fields, unused bits written as ones
    for (i = 0; i < 4; i++) begin
      v = ($urandom % 7) << 8 | ($urandom % 2) << 4 | $urandom % 10;
      m = ($urandom % 6) << 12 | ($urandom % 10) << 8
        | ($urandom % 6) << 4 | $urandom % 10;
      sync();
      ptr(RTCW_PTR_WH);
      wrw(v | 32'hffff_f8c0);
      ptr(RTCW_PTR_MS);
      wrw(m | 32'hffff_8080);
      rdw(m);
      ptr(RTCW_PTR_WH);
      rdw(v);
    end
    // a high-lane write clears minutes only, seconds keep their value
    ptr(RTCW_PTR_MS);
    xfer(1'b1, RTCW_OFF_WINDOW, 32'h0000_0000, 4'h2, 33'h0);
    rdw(m & 32'h0000_00ff);
    $display("test fields done");
    // one tick across each carry boundary
    for (i = 0; i < 4; i++) begin
      sync();
      ptr(RTCW_PTR_WH);
      wrw(32'(CARRY[i][0]));
      ptr(RTCW_PTR_MS);
      wrw(32'(CARRY[i][1]));
      sync();
      rdw(32'(CARRY[i][3]));
      ptr(RTCW_PTR_WH);
      rdw(32'(CARRY[i][2]));
    end
    $display("test carry done");
    // let the monitor take the last answer before the verdict
    @(posedge pclk);
    if (exp_q.size() != 0) error_cnt++;
    conclude();
  end
endmodule : rtcw_window_test
